// file: hdl/blpd_pkg.sv
// Package of constants and types for the bit-logic program decoder.
package blpd_pkg;
  localparam int unsigned PROG_BYTES     = 256;   // Program area size in bytes.
  localparam int unsigned PARAM_COUNT    = 256;   // Number of 16-bit parameters.
  localparam logic [7:0]  FLAG_COPY_LIMIT = 8'h04; // Flag copies at or above this are ignored.
  localparam logic [3:0]  OP_LOAD        = 4'h0;
  localparam logic [3:0]  OP_LOAD_N      = 4'h1;
  localparam logic [3:0]  OP_STORE       = 4'h2;
  localparam logic [3:0]  OP_STORE_N     = 4'h3;
  localparam logic [3:0]  OP_AND         = 4'h4;
  localparam logic [3:0]  OP_AND_N       = 4'h5;
  localparam logic [3:0]  OP_OR          = 4'h6;
  localparam logic [3:0]  OP_OR_N        = 4'h7;
  localparam logic [3:0]  OP_ADD         = 4'h8;
  localparam logic [3:0]  OP_SUB         = 4'h9;
  localparam logic [3:0]  OP_PRODUCT     = 4'ha;
  localparam logic [3:0]  OP_DIV         = 4'hb;
  localparam logic [3:0]  OP_SET         = 4'hc;
  localparam logic [3:0]  OP_CLR         = 4'hd;
  localparam logic [3:0]  OP_FLAG_COPY   = 4'he;
  localparam logic [3:0]  OP_END         = 4'hf;
  localparam int unsigned OPC_LSB        = 0;     // Opcode in bits 3..0 of byte one.
  localparam int unsigned IDX_LSB        = 4;     // Bit index in bits 7..4 of byte one.
  localparam int unsigned FC_SRC_BIT     = 4;     // Flag copy source select.
  localparam int unsigned FC_INV_BIT     = 5;     // Flag copy inversion.
  localparam logic [7:0]  LEN_SHORT      = 8'h02;
  localparam logic [7:0]  LEN_LONG       = 8'h04;

  // Sequencer states, one-hot.
  typedef enum logic [5:0] {
    BLPD_IDLE  = 6'b000001,
    BLPD_F0    = 6'b000010,
    BLPD_F1    = 6'b000100,
    BLPD_F2    = 6'b001000,
    BLPD_F3    = 6'b010000,
    BLPD_EXEC  = 6'b100000
  } blpd_state_t;
endpackage

// file: hdl/blpd_decoder.sv
// Bit-logic program store, decoder and sequencer.
`timescale 1ns/1ps
// Summary of operation
// - Opcode from low nibble selects operation, length.
// - Bit ops: index upper nibble, parameter byte two.
// - Arithmetic: target, operands from bytes two-four.
// - End is two bytes; second ignored.
// - Flag copy bit four selects source flags.
// - Flag copy bit five inverts copied bit.
// - Flag copy bit index from byte two.
// - Flag copy at address four onward: no-op.
// - Single program; stop pass at end.
// - Program area holds 256 bytes.
// - Host reads, writes program at 0..255.
module blpd_decoder #(
  parameter int unsigned PROG_DEPTH = blpd_pkg::PROG_BYTES,
  parameter int unsigned PAR_DEPTH  = blpd_pkg::PARAM_COUNT
) (
  // Clock and reset.
  input  wire logic        clock_in,
  input  wire logic        arst_n_in,
  // Run control: a pass starts at a scan request seen while idle; requests while busy are ignored.
  input  wire logic        scan_start_in,
  // Host program port, one byte per cycle.
  input  wire logic        prog_wr_in,
  input  wire logic [7:0]  prog_addr_in,
  input  wire logic [7:0]  prog_wdata_in,
  output logic      [7:0]  prog_rdata_out,
  // Host parameter port for seeding and observing parameters.
  input  wire logic        par_wr_in,
  input  wire logic [7:0]  par_addr_in,
  input  wire logic [15:0] par_wdata_in,
  output logic      [15:0] par_rdata_out,
  // Flag sources for the flag copy instruction.
  input  wire logic [15:0] drive_control_flags_in,
  input  wire logic [15:0] bus_option_flags_in,
  // Status.
  output logic             busy_out,
  output logic             pass_done_out,
  output logic      [7:0]  pc_out
);
  import blpd_pkg::*;

  // Program bytes and parameter words live in arrays outside the state struct.
  // The arrays have no reset; a pass over bytes never written decodes unknowns.
  logic [7:0]  prog_mem [PROG_DEPTH];
  logic [15:0] par_mem  [PAR_DEPTH];

  // All sequencer state in one struct.
  typedef struct packed {
    blpd_state_t st;
    logic [7:0]  pc;       // Program pointer.
    logic [7:0]  b0;       // Instruction bytes.
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic        acc;      // Bit accumulator.
    logic        done;     // Pass finished pulse.
    logic [7:0]  prd;      // Host program read data.
    logic [15:0] prr;      // Host parameter read data.
  } blpd_regs_t;

  blpd_regs_t  r_q;
  blpd_regs_t  r_d;

  // Write strobe and data for the parameter array from the sequencer.
  logic        exe_wr;
  logic [7:0]  exe_addr;
  logic [15:0] exe_data;

  // Decoded fields and fetched operands of the instruction in hand.
  logic [3:0]  opc;
  logic [3:0]  bidx;
  logic [15:0] tgt_wd;
  logic [15:0] op1;
  logic [15:0] op2;
  logic [31:0] prod;
  logic        pbit;
  logic        fsrc;

  // Field extraction and operand fetch.
  always_comb begin
    opc     = r_q.b0[OPC_LSB +: 4];
    bidx    = r_q.b0[IDX_LSB +: 4];
    tgt_wd  = par_mem[r_q.b1];
    op1     = par_mem[r_q.b2];
    op2     = par_mem[r_q.b3];
    prod    = op1 * op2;
    pbit    = tgt_wd[bidx];
    // Source chosen by bit four, index by byte two, optional inversion.
    fsrc    = (r_q.b0[FC_SRC_BIT] ? bus_option_flags_in[r_q.b1[3:0]]
                                  : drive_control_flags_in[r_q.b1[3:0]])
              ^ r_q.b0[FC_INV_BIT];
  end

  // Next state and execution.
  always_comb begin
    r_d      = r_q;
    r_d.done = 1'b0;
    exe_wr   = 1'b0;
    exe_addr = r_q.b1;
    exe_data = tgt_wd;
    r_d.prd  = prog_mem[prog_addr_in];
    r_d.prr  = par_mem[par_addr_in];
    unique case (r_q.st)
      BLPD_IDLE: begin
        if (scan_start_in) begin
          r_d.pc = 8'h00;
          r_d.st = BLPD_F0;
        end
      end
      // Fetches read the area directly; the pointer wraps at the area end.
      BLPD_F0: begin
        r_d.b0 = prog_mem[r_q.pc];
        r_d.st = BLPD_F1;
      end
      BLPD_F1: begin
        r_d.b1 = prog_mem[r_q.pc + 8'h01];
        // Four-byte instructions fetch two more bytes.
        r_d.st = (r_q.b0[3:2] == 2'b10) ? BLPD_F2 : BLPD_EXEC;
      end
      BLPD_F2: begin
        r_d.b2 = prog_mem[r_q.pc + 8'h02];
        r_d.st = BLPD_F3;
      end
      BLPD_F3: begin
        r_d.b3 = prog_mem[r_q.pc + 8'h03];
        r_d.st = BLPD_EXEC;
      end
      BLPD_EXEC: begin
        // The write lands before the next fetch begins.
        r_d.st = BLPD_F0;
        unique case (opc)
          // Bit logic only moves the accumulator; no parameter is written.
          OP_LOAD:    r_d.acc = pbit;
          OP_LOAD_N:  r_d.acc = ~pbit;
          OP_AND:     r_d.acc = r_q.acc & pbit;
          OP_AND_N:   r_d.acc = r_q.acc & ~pbit;
          OP_OR:      r_d.acc = r_q.acc | pbit;
          OP_OR_N:    r_d.acc = r_q.acc | ~pbit;
          // Stores, sets and clears rewrite one bit of the target word in place.
          OP_STORE, OP_STORE_N, OP_SET, OP_CLR: begin
            exe_wr = 1'b1;
            exe_data[bidx] = (opc == OP_STORE)   ? r_q.acc :
                             (opc == OP_STORE_N) ? ~r_q.acc :
                             (opc == OP_SET);
          end
          // Arithmetic keeps the low sixteen bits; carries and borrows are lost.
          OP_ADD: begin
            exe_wr   = 1'b1;
            exe_data = op1 + op2;
          end
          OP_SUB: begin
            exe_wr   = 1'b1;
            exe_data = op1 - op2;
          end
          OP_PRODUCT: begin
            exe_wr   = 1'b1;
            exe_data = prod[15:0];
          end
          OP_DIV: begin
            // Division by zero leaves the target at all ones.
            exe_wr   = 1'b1;
            exe_data = (op2 == 16'h0000) ? 16'hffff : op1 / op2;
          end
          OP_FLAG_COPY: begin
            // Flag copies only work inside the first two slots.
            if (r_q.pc < FLAG_COPY_LIMIT) begin
              r_d.acc = fsrc;
            end
          end
          OP_END: begin
            // Second byte is not looked at; the pass ends here.
            r_d.st   = BLPD_IDLE;
            r_d.done = 1'b1;
          end
        endcase
        if (opc != OP_END) begin
          // Pointer steps by the instruction length; wraps at the area end.
          r_d.pc = r_q.pc + ((r_q.b0[3:2] == 2'b10) ? LEN_LONG : LEN_SHORT);
        end else begin
          r_d.pc = 8'h00;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r_q <= '{st: BLPD_IDLE, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // Program memory; the host writes it, addresses 0 to 255.
  always_ff @(posedge clock_in) begin
    if (prog_wr_in) begin
      prog_mem[prog_addr_in] <= prog_wdata_in;
    end
  end

  // Parameter memory; the sequencer has priority over a host write.
  always_ff @(posedge clock_in) begin
    if (exe_wr) begin
      par_mem[exe_addr] <= exe_data;
    end else if (par_wr_in) begin
      par_mem[par_addr_in] <= par_wdata_in;
    end
  end

  // Outputs from flip-flops.
  always_comb begin
    prog_rdata_out = r_q.prd;
    par_rdata_out  = r_q.prr;
    busy_out       = (r_q.st != BLPD_IDLE);
    pass_done_out  = r_q.done;
    pc_out         = r_q.pc;
  end
endmodule

// file: testbench/blpd_decoder_chk.sv
// Checker for the decoder's sequencing outputs.
`timescale 1ns/1ps
module blpd_decoder_chk (
  // Clock, reset and run request.
  input wire logic       clock_in,
  input wire logic       arst_n_in,
  input wire logic       scan_start_in,
  // Status outputs.
  input wire logic       busy_out,
  input wire logic       pass_done_out,
  input wire logic [7:0] pc_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  property p_start; !busy_out && scan_start_in |=> busy_out && pc_out == 8'h00; endproperty
  a_start: assert property (p_start) else $error("pass did not start at zero");
  property p_rose; $rose(busy_out) |-> $past(scan_start_in); endproperty
  a_rose: assert property (p_rose) else $error("busy without a request");
  property p_step; busy_out && $past(busy_out) && $changed(pc_out) |->
    pc_out == $past(pc_out) + 8'h02 || pc_out == $past(pc_out) + 8'h04; endproperty
  a_step: assert property (p_step) else $error("pointer step not two or four");
  property p_hold; busy_out && $changed(pc_out) |=> $stable(pc_out) [*2]; endproperty
  a_hold: assert property (p_hold) else $error("instruction shorter than a step");
  property p_min; $rose(busy_out) |=> busy_out [*2]; endproperty
  a_min: assert property (p_min) else $error("pass ended too soon");
  property p_pulse; pass_done_out |=> !pass_done_out; endproperty
  a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
  property p_idle; pass_done_out |-> !busy_out && pc_out == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("done while busy or off zero");
  property p_fell; $fell(busy_out) |-> pass_done_out; endproperty
  a_fell: assert property (p_fell) else $error("pass stopped without done");
  c_pass: cover property ($rose(busy_out));
  c_done: cover property (pass_done_out);
  c_long: cover property (busy_out && pc_out == $past(pc_out) + 8'h04);
endmodule

// file: testbench/blpd_host.sv
// Host model that downloads a program into the decoder's program area.
`timescale 1ns/1ps
module blpd_host (
  // Clock.
  input  wire logic  clock_in,
  // Program write port.
  output logic       prog_wr_out,
  output logic [7:0] prog_addr_out,
  output logic [7:0] prog_wdata_out
);
  initial begin
    prog_wr_out = 1'b0;
    prog_addr_out = 8'h00;
    prog_wdata_out = 8'h00;
  end
  // Bytes go out back to back from address zero, leaving no gaps.
  task automatic load(input logic [7:0] bytes[$]);
    foreach (bytes[i]) begin
      @(posedge clock_in);
      #1 prog_addr_out = 8'(i);
      prog_wdata_out = bytes[i];
      prog_wr_out = 1'b1;
    end
    @(posedge clock_in);
    #1 prog_wr_out = 1'b0;
    prog_wdata_out = ~prog_wdata_out; // Released data must not look stale.
  endtask
  // Points the read port at one byte; the byte follows one edge later.
  task automatic point(input logic [7:0] a);
    @(posedge clock_in);
    #1 prog_addr_out = a;
  endtask
endmodule

// file: testbench/blpd_decoder_bench.sv
// Bench running two programs with flag copies, bit and arithmetic steps.
`timescale 1ns/1ps
module blpd_decoder_bench;
  logic        clock_in = 1'b0, arst_n_in = 1'b0, scan_start_in = 1'b0, par_wr_in = 1'b0;
  logic        prog_wr, busy_out, pass_done_out;
  logic [7:0]  prog_addr, prog_wdata, prog_rdata_out, pc_out, par_addr_in = 8'h00;
  logic [15:0] par_wdata_in = 16'h0000, par_rdata_out;
  logic [15:0] drive_flags = 16'h0008; // Bit three set, so a wrong pick shows.
  logic [15:0] bus_flags = 16'hfff7;   // Bit three clear, inverted to one.
  int          fails = 0, samples_checked = 0, cycles = 0;
  logic [7:0]  prog[$] = {8'h3e, 8'h03, 8'h22, 8'h05, 8'h08, 8'h0a, 8'h01, 8'h02,
    8'h0a, 8'h0b, 8'h01, 8'h02, 8'h0b, 8'h0c, 8'h02, 8'h01, 8'h09, 8'h0d, 8'h02, 8'h01,
    8'h00, 8'h01, 8'h0e, 8'h03, 8'h13, 8'h06, 8'hfc, 8'h07, 8'h0f, 8'ha5, 8'h0c, 8'h08};
  // Second program: drive-flag copy, then OP_LOAD_N, OP_AND, OP_OR_N, OP_OR and OP_AND_N results stored into param 8.
  logic [7:0]  prog2[$] = {8'h0e, 8'h03, 8'h22, 8'h05, 8'h08, 8'h0a, 8'h01, 8'h02,
    8'h11, 8'h01, 8'h02, 8'h08, 8'h34, 8'h01, 8'h12, 8'h08, 8'h27, 8'h01, 8'h22, 8'h08,
    8'h06, 8'h01, 8'h32, 8'h08, 8'h15, 8'h01, 8'h42, 8'h08, 8'h5d, 8'h08, 8'h0f, 8'h00};
  always #25 clock_in = ~clock_in;
  blpd_decoder blpd_decoder_inst (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .scan_start_in(scan_start_in), .prog_wr_in(prog_wr), .prog_addr_in(prog_addr),
    .prog_wdata_in(prog_wdata), .prog_rdata_out(prog_rdata_out), .par_wr_in(par_wr_in),
    .par_addr_in(par_addr_in), .par_wdata_in(par_wdata_in), .par_rdata_out(par_rdata_out),
    .drive_control_flags_in(drive_flags), .bus_option_flags_in(bus_flags),
    .busy_out(busy_out), .pass_done_out(pass_done_out), .pc_out(pc_out));
  blpd_host blpd_host_inst (.clock_in(clock_in), .prog_wr_out(prog_wr),
    .prog_addr_out(prog_addr), .prog_wdata_out(prog_wdata));
  // Compares one word and reports a mismatch at once.
  task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Writes one word, then lets an edge pass with the strobe low.
  task automatic par_put(input logic [7:0] a, input logic [15:0] d);
    par_addr_in = a;
    par_wdata_in = d;
    par_wr_in = 1'b1;
    @(posedge clock_in);
    #1 par_wr_in = 1'b0;
    @(posedge clock_in);
    #1;
  endtask
  // Read data is registered, so it is taken one edge after the address.
  task automatic par_check(input logic [7:0] a, input logic [15:0] exp);
    par_addr_in = a;
    @(posedge clock_in);
    #1 chk16($sformatf("param %0d", a), exp, par_rdata_out);
  endtask
  // Reads one program byte back through the host port.
  task automatic prog_check(input logic [7:0] a, input logic [7:0] exp);
    blpd_host_inst.point(a);
    @(posedge clock_in);
    #1 chk16($sformatf("program byte %0d", a), {8'h00, exp}, {8'h00, prog_rdata_out});
  endtask
  // Starts a pass and counts cycles to done under a bound.
  task automatic run_pass(input int len);
    int n = 0;
    scan_start_in = 1'b1;
    @(posedge clock_in);
    #1 scan_start_in = 1'b0;
    while (pass_done_out !== 1'b1 && n < 200) begin
      @(posedge clock_in);
      #1 n++;
    end
    chk16("pass cycles", 16'(len), 16'(n));
    chk16("pointer after end", 16'h0000, {8'h00, pc_out});
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // A hang is cut short well beyond the expected run time.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      summarize();
    end
  end
  // First pass: option-flag copy, bit steps, all arithmetic, stray copy, end.
  task automatic first_pass();
    par_put(8'h01, 16'h0004);
    par_put(8'h02, 16'h1234);
    for (int i = 5; i < 9; i++) par_put(8'(i), 16'h0000);
    blpd_host_inst.load(prog);
    prog_check(8'h1c, 8'h0f);
    run_pass(41);
    par_check(8'h05, 16'h0004);
    par_check(8'h0a, 16'h1238);
    par_check(8'h0b, 16'h48d0);
    par_check(8'h0c, 16'h048d);
    par_check(8'h0d, 16'h1230);
    par_check(8'h06, 16'h0002);
    par_check(8'h07, 16'h8000);
    par_check(8'h08, 16'h0000);
  endtask
  // Second pass with a new operand: restart at zero, new sum, param 6 cleared by a loaded one.
  task automatic rerun_pass();
    par_put(8'h01, 16'h0005);
    run_pass(41);
    par_check(8'h0a, 16'h1239);
    par_check(8'h06, 16'h0000);
  endtask
  // Third pass: each bit-logic step flips one preset bit of param 8.
  task automatic logic_pass();
    par_put(8'h05, 16'h0000);
    par_put(8'h08, 16'h0026);
    par_put(8'h0a, 16'h0000);
    blpd_host_inst.load(prog2);
    prog_check(8'h1e, 8'h0f);
    run_pass(47);
    par_check(8'h05, 16'h0004);
    par_check(8'h08, 16'h0019);
    par_check(8'h0a, 16'h1239);
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    #1 arst_n_in = 1'b1;
    first_pass();
    rerun_pass();
    logic_pass();
    summarize();
  end
endmodule
bind blpd_decoder blpd_decoder_chk blpd_decoder_chk_inst (.clock_in(clock_in),
  .arst_n_in(arst_n_in), .scan_start_in(scan_start_in), .busy_out(busy_out),
  .pass_done_out(pass_done_out), .pc_out(pc_out));
